// ### scpc_pkg.sv
// constants for the serial configuration port controller
package scpc_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   // nonvolatile operation times in ms
   localparam int unsigned NV_OP_MIN_MS = 80;
   localparam int unsigned NV_OP_MAX_MS = 100;
   localparam int unsigned SETTLE_MS = 2;
   localparam int unsigned USER_CAL_TIME_MS = 100;
   localparam int unsigned POWERUP_CAL_TIME_MS = 250;
   localparam int unsigned CAL_PULSE_MIN_NS = 40;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   // least time rounds up
   localparam int unsigned CAL_PULSE_MIN_CYC = (CAL_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 32;
   // jtag instruction register
   localparam int unsigned IR_W = 4;
   localparam logic [3:0] IR_RESET = 4'h1;
   localparam logic [3:0] IR_BYPASS = 4'hf;
   localparam logic [3:0] IR_IDCODE = 4'h1;
   localparam logic [3:0] IR_ERASE = 4'h2;
   localparam logic [3:0] IR_PROGRAM = 4'h3;
   localparam logic [3:0] IR_CFG_LOAD = 4'h4;
   localparam logic [3:0] IR_CAL = 4'h5;
   localparam logic [1:0] IR_CAPTURE = 2'h1;
   // arbitrary identification value
   localparam logic [31:0] ID_CODE = 32'h0000_0001;
   // framed control word
   localparam int unsigned WORD_W = 8;
   localparam int unsigned GAIN_MSB_BIT = 7;
   localparam int unsigned GAIN_LSB_BIT = 6;
   localparam int unsigned BANK_BIT = 5;
   localparam int unsigned CAL_BIT = 4;
   localparam logic [7:0] WORD_RESET = 8'h00;
   localparam logic [1:0] GAIN_CODE_MAX = 2'h3;
   localparam logic [3:0] GAIN_X1 = 4'h1;
   localparam logic [3:0] GAIN_X2 = 4'h2;
   localparam logic [3:0] GAIN_X5 = 4'h5;
   localparam logic [3:0] GAIN_X10 = 4'ha;
   typedef enum logic [3:0] {
      TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAU_DR, TS_EX2_DR, TS_UPD_DR,
      TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
   } scpc_tap_e;
   typedef enum logic [1:0] {NV_NONE, NV_ERASE, NV_PROG} scpc_nv_e;
endpackage : scpc_pkg

// ### scpc_ctrl.sv
// serial configuration port controller: boundary-scan and chip-select framed modes
// What this block does
// - mode select high selects framed shift
// - test mode select ignored in framed mode
// - test clock clocks boundary-scan mode
// - data captured rising clock or select edge
// - output updates falling clock or select edge
// - chip select latches word into settings
// - calibration rising edge starts auto-calibration
// - user calibration finishes within 100 ms
// - power-up calibration runs, done within 250 ms
// - program runs in idle, 80 ms erase then 80 ms write
// - erase runs in idle, 80 to 100 ms
// - program cycle erases then rewrites, unclamped once bits settle
// - erase forces top gain, low corner
// - power-on clears framed shift register
// - eight-bit word: gain, bank, cal, don't-care
// - gain code maps to 1, 2, 5, 10
module scpc_ctrl
   import scpc_pkg::*;
#(
   parameter int unsigned NV_OP_CYC = NV_OP_MIN_MS * CYC_PER_MS,
   parameter int unsigned SETTLE_CYC = SETTLE_MS * CYC_PER_MS,
   parameter int unsigned USER_CAL_CYC = USER_CAL_TIME_MS * CYC_PER_MS,
   parameter int unsigned POWERUP_CAL_CYC = POWERUP_CAL_TIME_MS * CYC_PER_MS
) (
   input wire logic CLK_IN,
   input wire logic SRST_IN,
   input wire logic SERIAL_MODE_SELECT_IN,
   input wire logic TCK_IN,
   input wire logic TMS_IN,
   input wire logic TDI_IN,
   input wire logic CS_IN,
   input wire logic CAL_IN,
   output logic TDO_OUT,
   output logic TDO_OE_OUT,
   output logic GAIN_CODE_MSB_OUT,
   output logic GAIN_CODE_LSB_OUT,
   output logic [3:0] GAIN_FACTOR_OUT,
   output logic BANK_SELECT_OUT,
   output logic LOW_CORNER_OUT,
   output logic CAL_BUSY_OUT,
   output logic NV_BUSY_OUT,
   output logic NV_ERASING_OUT
);

   function automatic logic [3:0] gain_factor(input logic [1:0] code);
      case (code)
         2'h0: gain_factor = GAIN_X1;
         2'h1: gain_factor = GAIN_X2;
         2'h2: gain_factor = GAIN_X5;
         default: gain_factor = GAIN_X10;
      endcase
   endfunction : gain_factor

   // two-flop synchronisers for all pins
   localparam int unsigned NSYNC = 6;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic [NSYNC-1:0] prev_q;
   assign pin_raw = {SERIAL_MODE_SELECT_IN, TCK_IN, TMS_IN, TDI_IN, CS_IN, CAL_IN};
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end
   logic mode_s, tck_s, tms_s, tdi_s, cs_s, cal_s;
   assign {mode_s, tck_s, tms_s, tdi_s, cs_s, cal_s} = sync2_q;
   // edges held off until the edge flop holds a real pin sample
   localparam logic [1:0] ARM_FULL = 2'h3;
   logic [1:0] arm_q;
   logic armed;
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         arm_q <= '0;
      end else if (arm_q != ARM_FULL) begin
         arm_q <= arm_q + 1'b1;
      end
   end
   assign armed = arm_q == ARM_FULL;
   logic tck_rise, tck_fall, cs_rise, cal_rise;
   assign tck_rise = armed & tck_s & ~prev_q[4];
   assign tck_fall = armed & ~tck_s & prev_q[4];
   assign cs_rise = armed & cs_s & ~prev_q[1];
   assign cal_rise = armed & cal_s & ~prev_q[0];

   logic framed;
   assign framed = mode_s;
   logic jtag_rise, jtag_fall;
   assign jtag_rise = ~framed & tck_rise;
   assign jtag_fall = ~framed & tck_fall;
   logic spi_clk;
   // framed data clocked by test clock while select low
   assign spi_clk = framed & tck_rise & ~cs_s;

   // tap state machine; held in reset while mode select is high
   scpc_tap_e tap_q;
   scpc_tap_e tap_d;
   always_comb begin
      case (tap_q)
         TS_RESET: tap_d = tms_s ? TS_RESET : TS_IDLE;
         TS_IDLE: tap_d = tms_s ? TS_SEL_DR : TS_IDLE;
         TS_SEL_DR: tap_d = tms_s ? TS_SEL_IR : TS_CAP_DR;
         TS_CAP_DR: tap_d = tms_s ? TS_EX1_DR : TS_SH_DR;
         TS_SH_DR: tap_d = tms_s ? TS_EX1_DR : TS_SH_DR;
         TS_EX1_DR: tap_d = tms_s ? TS_UPD_DR : TS_PAU_DR;
         TS_PAU_DR: tap_d = tms_s ? TS_EX2_DR : TS_PAU_DR;
         TS_EX2_DR: tap_d = tms_s ? TS_UPD_DR : TS_SH_DR;
         TS_UPD_DR: tap_d = tms_s ? TS_SEL_DR : TS_IDLE;
         TS_SEL_IR: tap_d = tms_s ? TS_RESET : TS_CAP_IR;
         TS_CAP_IR: tap_d = tms_s ? TS_EX1_IR : TS_SH_IR;
         TS_SH_IR: tap_d = tms_s ? TS_EX1_IR : TS_SH_IR;
         TS_EX1_IR: tap_d = tms_s ? TS_UPD_IR : TS_PAU_IR;
         TS_PAU_IR: tap_d = tms_s ? TS_EX2_IR : TS_PAU_IR;
         TS_EX2_IR: tap_d = tms_s ? TS_UPD_IR : TS_SH_IR;
         TS_UPD_IR: tap_d = tms_s ? TS_SEL_DR : TS_IDLE;
         default: tap_d = TS_RESET;
      endcase
   end
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN || framed) begin
         tap_q <= TS_RESET;
      end else if (jtag_rise) begin
         tap_q <= tap_d;
      end
   end

   // instruction register
   logic [IR_W-1:0] ir_sh_q;
   logic [IR_W-1:0] ir_q;
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN || tap_q == TS_RESET) begin
         ir_sh_q <= '0;
         ir_q <= IR_RESET;
      end else if (jtag_rise) begin
         if (tap_q == TS_CAP_IR) begin
            ir_sh_q <= {{(IR_W-2){1'b0}}, IR_CAPTURE};
         end else if (tap_q == TS_SH_IR) begin
            ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
         end else if (tap_q == TS_UPD_IR) begin
            ir_q <= ir_sh_q;
         end
      end
   end

   // data registers: id, bypass, config word
   logic [31:0] dr_q;
   logic [WORD_W-1:0] cfg_q;
   logic [WORD_W-1:0] spi_sh_q;
   logic cfg_load;
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         dr_q <= '0;
      end else if (jtag_rise) begin
         if (tap_q == TS_CAP_DR) begin
            dr_q <= (ir_q == IR_IDCODE) ? ID_CODE : {24'h0, cfg_q};
         end else if (tap_q == TS_SH_DR) begin
            if (ir_q == IR_IDCODE) begin
               dr_q <= {tdi_s, dr_q[31:1]};
            end else if (ir_q == IR_CFG_LOAD) begin
               dr_q <= {24'h0, tdi_s, dr_q[WORD_W-1:1]};
            end else begin
               dr_q <= {31'h0, tdi_s};
            end
         end
      end
   end
   assign cfg_load = jtag_rise && tap_q == TS_UPD_DR && ir_q == IR_CFG_LOAD;

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         spi_sh_q <= WORD_RESET;
      // framed data shifted in, last bit lands on top
      end else if (spi_clk) begin
         spi_sh_q <= {tdi_s, spi_sh_q[WORD_W-1:1]};
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         cfg_q <= WORD_RESET;
      end else if (framed && cs_rise) begin
         cfg_q <= spi_sh_q;
      end else if (cfg_load) begin
         cfg_q <= dr_q[WORD_W-1:0];
      end
   end

   logic tdo_bit;
   always_comb begin
      case (tap_q)
         TS_SH_IR: tdo_bit = ir_sh_q[0];
         TS_SH_DR: tdo_bit = dr_q[0];
         default: tdo_bit = 1'b0;
      endcase
   end
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         TDO_OUT <= 1'b0;
         TDO_OE_OUT <= 1'b0;
      end else if (framed) begin
         TDO_OE_OUT <= 1'b1;
         if (cs_rise) begin
            TDO_OUT <= spi_sh_q[WORD_W-1];
         end
      end else if (jtag_fall) begin
         TDO_OUT <= tdo_bit;
         TDO_OE_OUT <= (tap_q == TS_SH_IR) || (tap_q == TS_SH_DR);
      end
   end

   // nonvolatile operation timer, runs only in idle or update-ir
   scpc_nv_e nv_q;
   logic [CNT_W-1:0] nv_cnt_q;
   logic nv_start;
   assign nv_start = jtag_rise && tap_q == TS_UPD_IR && (ir_sh_q == IR_ERASE || ir_sh_q == IR_PROGRAM);
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         nv_q <= NV_NONE;
         nv_cnt_q <= '0;
      end else if (nv_start) begin
         nv_q <= NV_ERASE;
         nv_cnt_q <= '0;
      end else if (nv_q != NV_NONE) begin
         if (tap_q != TS_IDLE && tap_q != TS_UPD_IR) begin
            nv_q <= NV_NONE;
         end else if (nv_cnt_q == CNT_W'(NV_OP_CYC - 1)) begin
            nv_cnt_q <= '0;
            nv_q <= (nv_q == NV_ERASE && ir_q == IR_PROGRAM) ? NV_PROG : NV_NONE;
         end else begin
            nv_cnt_q <= nv_cnt_q + 1'b1;
         end
      end
   end
   // erase settings held until bits settle in write
   logic erase_look;
   assign erase_look = (nv_q == NV_ERASE) || (nv_q == NV_PROG && nv_cnt_q < CNT_W'(SETTLE_CYC));
   // write spans full time regardless of settle
   assign NV_BUSY_OUT = nv_q != NV_NONE;
   assign NV_ERASING_OUT = nv_q == NV_ERASE;

   // calibration timer; power-up run after reset
   logic cal_busy_q;
   logic [CNT_W-1:0] cal_cnt_q;
   logic [CNT_W-1:0] cal_len_q;
   logic cal_cmd;
   assign cal_cmd = (framed && cs_rise && spi_sh_q[CAL_BIT]) || (jtag_rise && tap_q == TS_UPD_IR && ir_sh_q == IR_CAL);
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         cal_busy_q <= 1'b1;
         cal_cnt_q <= '0;
         cal_len_q <= CNT_W'(POWERUP_CAL_CYC);
      // sync stages need a pulse of a few cycles
      end else if (cal_rise || cal_cmd) begin
         cal_busy_q <= 1'b1;
         cal_cnt_q <= '0;
         cal_len_q <= CNT_W'(USER_CAL_CYC);
      end else if (cal_busy_q) begin
         if (cal_cnt_q >= cal_len_q - 1'b1) begin
            cal_busy_q <= 1'b0;
         end else begin
            cal_cnt_q <= cal_cnt_q + 1'b1;
         end
      end
   end
   assign CAL_BUSY_OUT = cal_busy_q;

   // gain decode, forced high during erase
   logic [1:0] gcode;
   assign gcode = erase_look ? GAIN_CODE_MAX : {cfg_q[GAIN_MSB_BIT], cfg_q[GAIN_LSB_BIT]};
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         GAIN_CODE_MSB_OUT <= 1'b0;
         GAIN_CODE_LSB_OUT <= 1'b0;
         GAIN_FACTOR_OUT <= GAIN_X1;
         BANK_SELECT_OUT <= 1'b0;
         LOW_CORNER_OUT <= 1'b0;
      end else begin
         GAIN_CODE_MSB_OUT <= gcode[1];
         GAIN_CODE_LSB_OUT <= gcode[0];
         GAIN_FACTOR_OUT <= gain_factor(gcode);
         BANK_SELECT_OUT <= cfg_q[BANK_BIT];
         LOW_CORNER_OUT <= erase_look;
      end
   end

endmodule : scpc_ctrl

// ### scpc_ctrl_sva.sv
// assertion checker for the serial configuration port controller
module scpc_ctrl_sva
   import scpc_pkg::*;
#(
   parameter int unsigned NV_OP_CYC = NV_OP_MIN_MS * CYC_PER_MS,
   parameter int unsigned POWERUP_CAL_CYC = POWERUP_CAL_TIME_MS * CYC_PER_MS
) (
   input wire logic CLK_IN,
   input wire logic SRST_IN,
   input wire logic SERIAL_MODE_SELECT_IN,
   input wire logic CS_IN,
   input wire logic CAL_IN,
   input wire logic TDO_OE_OUT,
   input wire logic GAIN_CODE_MSB_OUT,
   input wire logic GAIN_CODE_LSB_OUT,
   input wire logic [3:0] GAIN_FACTOR_OUT,
   input wire logic BANK_SELECT_OUT,
   input wire logic LOW_CORNER_OUT,
   input wire logic CAL_BUSY_OUT,
   input wire logic NV_BUSY_OUT,
   input wire logic NV_ERASING_OUT
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [CNT_W-1:0] nv_cnt_q;
   logic [CNT_W-1:0] cal_cnt_q;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (SRST_IN);
   // busy run lengths
   always_ff @(posedge CLK_IN) begin
      nv_cnt_q <= (SRST_IN || !NV_BUSY_OUT) ? '0 : nv_cnt_q + 1'b1;
      cal_cnt_q <= (SRST_IN || !CAL_BUSY_OUT) ? '0 : cal_cnt_q + 1'b1;
   end
   function automatic logic [3:0] fmap(input logic [1:0] c);
      return (c == 2'h0) ? GAIN_X1 : (c == 2'h1) ? GAIN_X2 : (c == 2'h2) ? GAIN_X5 : GAIN_X10;
   endfunction : fmap
   a_gain_map: assert property ((!LOW_CORNER_OUT && $stable({GAIN_CODE_MSB_OUT, GAIN_CODE_LSB_OUT}))[*2]
      |-> GAIN_FACTOR_OUT == fmap({GAIN_CODE_MSB_OUT, GAIN_CODE_LSB_OUT})) else $error("gain factor off");
   a_erase_gain: assert property (NV_ERASING_OUT[*3]
      |-> GAIN_FACTOR_OUT == GAIN_X10 && LOW_CORNER_OUT) else $error("erase gain off");
   a_erase_busy: assert property (NV_ERASING_OUT |-> NV_BUSY_OUT)
      else $error("erase without busy");
   a_nv_bound: assert property (nv_cnt_q <= 2 * NV_OP_CYC + 2)
      else $error("nonvolatile op too long");
   a_cal_bound: assert property (cal_cnt_q <= POWERUP_CAL_CYC + 2)
      else $error("calibration too long");
   a_cal_start: assert property ($rose(CAL_IN) |-> ##[1:6] CAL_BUSY_OUT)
      else $error("calibration not started");
   a_framed_oe: assert property (SERIAL_MODE_SELECT_IN[*5] |=> TDO_OE_OUT)
      else $error("framed output not driven");
   a_latch_hold: assert property ((SERIAL_MODE_SELECT_IN && !CS_IN)[*6]
      |=> $stable(BANK_SELECT_OUT) && $stable(GAIN_CODE_MSB_OUT)) else $error("settings moved without latch");
   c_erase: cover property ($rose(NV_ERASING_OUT));
   c_cal_done: cover property ($fell(CAL_BUSY_OUT));
   c_bank_b: cover property ($rose(BANK_SELECT_OUT));
endmodule : scpc_ctrl_sva

bind scpc_ctrl scpc_ctrl_sva #(.NV_OP_CYC(NV_OP_CYC), .POWERUP_CAL_CYC(POWERUP_CAL_CYC)) u_sva (
   .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .SERIAL_MODE_SELECT_IN(SERIAL_MODE_SELECT_IN), .CS_IN(CS_IN),
   .CAL_IN(CAL_IN), .TDO_OE_OUT(TDO_OE_OUT), .GAIN_CODE_MSB_OUT(GAIN_CODE_MSB_OUT),
   .GAIN_CODE_LSB_OUT(GAIN_CODE_LSB_OUT), .GAIN_FACTOR_OUT(GAIN_FACTOR_OUT), .BANK_SELECT_OUT(BANK_SELECT_OUT),
   .LOW_CORNER_OUT(LOW_CORNER_OUT), .CAL_BUSY_OUT(CAL_BUSY_OUT), .NV_BUSY_OUT(NV_BUSY_OUT),
   .NV_ERASING_OUT(NV_ERASING_OUT)
);

// ### scpc_host.sv
// far-side host model: link clock, test mode select, data and chip select
module scpc_host (
   input wire logic clk,
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic cs
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      cs = 1'b1;
   end
   // half of the 80 ns link period
   task automatic half();
      repeat (4) @(posedge clk);
      #1;
   endtask : half
   task automatic bit_out(input logic m, input logic d);
      tms = m;
      tdi = d;
      half();
      tck = 1'b1;
      half();
      tck = 1'b0;
   endtask : bit_out
   task automatic send_word(input logic [7:0] w);
      cs = 1'b0;
      half();
      for (int i = 0; i < 8; i++) bit_out(i[0], w[i]);
      half();
      cs = 1'b1;
      half();
      tdi = ~tdi;
   endtask : send_word
   task automatic tap_reset();
      repeat (5) bit_out(1'b1, 1'b0);
      bit_out(1'b0, 1'b0);
   endtask : tap_reset
   // config word through the data path, ends in idle
   task automatic dr_load(input logic [7:0] w);
      bit_out(1'b1, 1'b0);
      bit_out(1'b0, 1'b0);
      bit_out(1'b0, 1'b0);
      for (int i = 0; i < 8; i++) bit_out(i == 7, w[i]);
      bit_out(1'b1, 1'b0);
      bit_out(1'b0, 1'b0);
   endtask : dr_load
   task automatic ir_load(input logic [3:0] code);
      for (int i = 0; i < 4; i++) bit_out(i < 2, 1'b0);
      for (int i = 0; i < 4; i++) bit_out(i == 3, code[i]);
      bit_out(1'b1, 1'b0);
      bit_out(1'b0, 1'b0);
      tdi = ~tdi;
   endtask : ir_load
endmodule : scpc_host

// ### serial_config_port_ctrl_tb.sv
// self-checking bench for the serial configuration port controller
module serial_config_port_ctrl_tb
   import scpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NV = 100;
   localparam int ST = 10;
   localparam int UC = 50;
   localparam int PC = 80;
   logic clk, srst, mode, cal, tck, tms, tdi, cs, tdo, tdo_oe, g_msb, g_lsb, bank, low_corner, cal_busy, nv_busy, nv_er;
   logic [3:0] gain;
   logic [3:0] gtab [4];
   int err_total = 0;
   int tests_run = 0;
   int n;
   always #5 clk = ~clk;
   scpc_ctrl #(.NV_OP_CYC(NV), .SETTLE_CYC(ST), .USER_CAL_CYC(UC), .POWERUP_CAL_CYC(PC)) u_dut (
      .CLK_IN(clk), .SRST_IN(srst), .SERIAL_MODE_SELECT_IN(mode), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi),
      .CS_IN(cs), .CAL_IN(cal), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe), .GAIN_CODE_MSB_OUT(g_msb),
      .GAIN_CODE_LSB_OUT(g_lsb), .GAIN_FACTOR_OUT(gain), .BANK_SELECT_OUT(bank), .LOW_CORNER_OUT(low_corner),
      .CAL_BUSY_OUT(cal_busy), .NV_BUSY_OUT(nv_busy), .NV_ERASING_OUT(nv_er)
   );
   scpc_host u_host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .cs(cs));
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step
   task automatic wait_cal(input int lim);
      for (n = 0; n < lim && cal_busy !== 1'b0; n++) step(1);
      check(n < lim, 1);
   endtask : wait_cal
   task automatic nv_run(input int mid, input logic [3:0] exp);
      for (n = 0; n < 3 * NV && nv_busy === 1'b1; n++) begin
         if (n == mid) begin
            check({nv_er, low_corner}, exp);
         end
         step(1);
      end
   endtask : nv_run
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   initial begin
      gtab = '{GAIN_X1, GAIN_X2, GAIN_X5, GAIN_X10};
      clk = 1'b0;
      srst = 1'b1;
      mode = 1'b1;
      cal = 1'b0;
      step(2);
      srst = 1'b0;
      step(1);
      check(cal_busy, 1);
      check(gain, GAIN_X1);
      check(bank, 0);
      wait_cal(PC + 8);
      $display("power-up test done");
      for (int g = 0; g < 4; g++) begin
         u_host.send_word({g[1:0], g[0], 1'b0, 4'h5});
         step(6);
         check({g_msb, g_lsb}, g[1:0]);
         check(gain, gtab[g]);
         check(bank, g[0]);
         check(tdo, g[1]);
      end
      check(tdo_oe, 1);
      $display("framed test done");
      // request held 5 cycles, past the 40 ns minimum
      cal = 1'b1;
      step(5);
      cal = 1'b0;
      step(6);
      check(cal_busy, 1);
      wait_cal(UC + 8);
      u_host.send_word(8'h10);
      check(cal_busy, 1);
      check(gain, GAIN_X1);
      wait_cal(UC + 8);
      $display("calibration test done");
      mode = 1'b0;
      step(5);
      u_host.tap_reset();
      u_host.ir_load(IR_ERASE);
      step(6);
      check({nv_er, low_corner}, 3);
      check(gain, GAIN_X10);
      nv_run(NV / 2, 3);
      check(n >= NV - 20 && n <= NV, 1);
      u_host.ir_load(IR_PROGRAM);
      step(6);
      check({nv_er, low_corner}, 3);
      nv_run(NV + ST + 4, 0);
      check(n >= 2 * NV - 20 && n <= 2 * NV, 1);
      $display("nonvolatile test done");
      u_host.ir_load(IR_CFG_LOAD);
      u_host.dr_load(8'ha0);
      step(6);
      check({g_msb, g_lsb}, 2);
      check(gain, GAIN_X5);
      check(bank, 1);
      u_host.ir_load(IR_CAL);
      check(cal_busy, 1);
      wait_cal(UC + 8);
      $display("boundary-scan load test done");
      results();
   end
endmodule : serial_config_port_ctrl_tb
